/* logic/bfp_core.sv */
// Fault supervisor of a multi-phase buck controller: qualifies voltage, current
// and temperature faults, sequences hiccup and latch-off, drives tri-level PWM.
// Assumes comparator levels from the analog front end and a reference generator
// that runs soft start while soft_start_run_o is high.
`timescale 1ns/1ns
module bfp_core #(
  parameter int PHASES       = 6,
  parameter int REF_W        = 12,
  parameter int IMON_W       = 10,
  parameter int IMAX_W       = 16,
  parameter int PG_DELAY_CYC = 1000,
  parameter int HICCUP_CYC   = 1000000
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              main_supply_5v_ok_i,
  input  wire logic              enable_i,
  input  wire logic              fault_mode_select_pin_i,
  input  wire logic              function_select_pin_i,
  input  wire logic              ov_above_threshold_i,
  input  wire logic              ov_below_hysteresis_i,
  input  wire logic              uv_below_threshold_i,
  input  wire logic [PHASES-1:0] oc_phase_limit_i,
  input  wire logic              current_limit_over_thermal_i,
  input  wire logic              current_limit_below_reset_i,
  input  wire logic              external_temp_over_ref_i,
  input  wire logic              sw_cycle_start_i,
  input  wire logic [PHASES-1:0] pwm_demand_i,
  input  wire logic              soft_start_done_i,
  input  wire logic [REF_W-1:0]  dac_code_i,
  input  wire logic [IMON_W-1:0] imon_code_i,
  input  wire logic [IMAX_W-1:0] imax_amps_i,
  input  wire logic              cmd_read_i,
  input  wire logic [7:0]        cmd_code_i,
  output logic                   power_good_flag_o,
  output logic      [PHASES-1:0] pwm_high_on_o,
  output logic      [PHASES-1:0] pwm_low_on_o,
  output logic                   ov_thr_fixed_o,
  output logic      [REF_W-1:0]  ref_code_o,
  output logic                   soft_start_run_o,
  output logic                   fault_latched_o,
  output logic                   rsp_valid_o,
  output logic                   rsp_ack_o,
  output logic      [15:0]       rsp_data_o
);
  import bfp_pkg::*;

  localparam int SYNC_W = SY_OC_BASE + PHASES;

  logic [SYNC_W-1:0]      raw_in, sync1_r, sync2_r, sync3_r, filt_r;
  bfp_state_type          state_r, state_nxt;
  logic [OV_CNT_W-1:0]    ov_cnt_r;
  logic [UV_CNT_W-1:0]    uv_cnt_r;
  logic [OC_CNT_W-1:0]    oc_cnt_r;
  logic [RAMP_CNT_W-1:0]  ramp_cnt_r;
  logic [31:0]            wait_cnt_r;
  logic [PHASES-1:0]      oc_hit_r, oc_now, pwm_hi_nxt, pwm_lo_nxt;
  logic                   ls_on_r, ov_fixed_r, hiccup_ot_r;
  logic [7:0]             iout_code;
  logic                   s_run, s_latch_mode, s_ov_above, s_ov_below, s_uv_below;
  logic                   ot_hot, ot_cool, ov_en, uv_en, oc_en;
  logic                   ov_trip, uv_trip, oc_trip, ot_trip, tri_trip, ramp_tick;

  assign raw_in = {oc_phase_limit_i,
                   external_temp_over_ref_i,
                   current_limit_below_reset_i,
                   current_limit_over_thermal_i,
                   uv_below_threshold_i,
                   ov_below_hysteresis_i,
                   ov_above_threshold_i,
                   function_select_pin_i,
                   fault_mode_select_pin_i,
                   enable_i,
                   main_supply_5v_ok_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          {sync1_r[gi], sync2_r[gi], sync3_r[gi], filt_r[gi]} <= 4'h0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  assign s_run        = filt_r[SY_SUPPLY] & filt_r[SY_ENABLE];
  assign s_latch_mode = (filt_r[SY_FMODE] != MODE_RECOVER);
  assign s_ov_above   = filt_r[SY_OV_ABOVE];
  assign s_ov_below   = filt_r[SY_OV_BELOW];
  assign s_uv_below   = filt_r[SY_UV_BELOW];
  assign oc_now       = filt_r[SY_OC_BASE +: PHASES];

  assign ot_hot  = (filt_r[SY_FSEL] == FN_TEMP_CFG1) ? filt_r[SY_OT1_HOT]
                                                    : filt_r[SY_OT2_HOT];
  assign ot_cool = (filt_r[SY_FSEL] == FN_TEMP_CFG1) ? filt_r[SY_OT1_COOL]
                                                    : ~filt_r[SY_OT2_HOT];

  assign ov_en = (state_r == ST_SOFTSTART) || (state_r == ST_PG_DELAY) ||
                 (state_r == ST_REGULATE);
  assign uv_en = (state_r == ST_REGULATE);
  assign oc_en = ov_en;

  assign ov_trip  = ov_en && s_ov_above && (ov_cnt_r == OV_CNT_W'(OV_QUAL_CYC));
  assign uv_trip  = uv_en && s_uv_below && (uv_cnt_r == UV_CNT_W'(UV_QUAL_CYC));
  assign oc_trip  = oc_en && sw_cycle_start_i && (&oc_hit_r) &&
                    (oc_cnt_r == OC_CNT_W'(OC_PERSIST_CYCLES));
  assign ot_trip  = oc_en && ot_hot;
  assign tri_trip = uv_trip || oc_trip || ot_trip;
  assign ramp_tick = (ramp_cnt_r == RAMP_CNT_W'(RAMP_STEP_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_cnt_r <= '0;
    end else begin
      ov_cnt_r <= (ov_en && s_ov_above && !ov_trip) ? ov_cnt_r + 1'b1 : '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_cnt_r <= '0;
    end else begin
      uv_cnt_r <= (uv_en && s_uv_below && !uv_trip) ? uv_cnt_r + 1'b1 : '0;
    end
  end

  // per-phase hit, new hit wins over cycle restart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_hit_r <= '0;
    end else if (!oc_en) begin
      oc_hit_r <= '0;
    end else if (sw_cycle_start_i) begin
      oc_hit_r <= oc_now;
    end else begin
      oc_hit_r <= oc_hit_r | oc_now;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_cnt_r <= '0;
    end else if (!oc_en) begin
      oc_cnt_r <= '0;
    end else if (sw_cycle_start_i) begin
      if (!(&oc_hit_r)) begin
        oc_cnt_r <= '0;
      end else if (oc_cnt_r != OC_CNT_W'(OC_PERSIST_CYCLES)) begin
        oc_cnt_r <= oc_cnt_r + 1'b1;
      end
    end
  end

  // Fault sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DISABLED: begin
        if (s_run) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART, ST_PG_DELAY, ST_REGULATE: begin
        if (ov_trip) begin
          state_nxt = s_latch_mode ? ST_OV_RAMP : ST_OV_RECOV;
        end else if (tri_trip) begin
          state_nxt = s_latch_mode ? ST_TRI_LATCH : ST_HICCUP;
        end else if (state_r == ST_SOFTSTART && soft_start_done_i) begin
          state_nxt = ST_PG_DELAY;
        end else if (state_r == ST_PG_DELAY && wait_cnt_r == 32'(PG_DELAY_CYC)) begin
          state_nxt = ST_REGULATE;
        end
      end
      ST_OV_RECOV: begin
        if (s_ov_below) begin
          state_nxt = soft_start_done_i ? ST_REGULATE : ST_SOFTSTART;
        end
      end
      ST_OV_RAMP: begin
        if (ref_code_o == '0) begin
          state_nxt = ST_OV_LATCH;
        end
      end
      ST_HICCUP: begin
        if (wait_cnt_r == 32'(HICCUP_CYC) && (!hiccup_ot_r || ot_cool)) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
    // only a supply or enable drop clears a latch
    if (!s_run) begin
      state_nxt = ST_DISABLED;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shared wait counter for good delay and hiccup interval
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      wait_cnt_r <= '0;
    end else if ((state_r == ST_PG_DELAY || state_r == ST_HICCUP) &&
                 wait_cnt_r != 32'(HICCUP_CYC)) begin
      wait_cnt_r <= wait_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hiccup_ot_r <= 1'b0;
    end else if (state_nxt == ST_HICCUP && state_r != ST_HICCUP) begin
      hiccup_ot_r <= ot_trip;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_fixed_r <= 1'b0;
    end else if (state_r == ST_DISABLED || state_r == ST_HICCUP) begin
      ov_fixed_r <= 1'b1;
    end else if (ov_trip || state_nxt == ST_REGULATE) begin
      ov_fixed_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_cnt_r <= '0;
    end else begin
      ramp_cnt_r <= (state_r != ST_OV_RAMP || ramp_tick) ? '0 : ramp_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_code_o <= '0;
    end else if (state_r == ST_OV_LATCH) begin
      ref_code_o <= '0;
    end else if (state_r == ST_OV_RAMP) begin
      if (ramp_tick && ref_code_o != '0) begin
        ref_code_o <= ref_code_o - 1'b1;
      end
    end else begin
      ref_code_o <= dac_code_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ls_on_r <= 1'b1;
    end else if (state_r != ST_OV_RAMP || s_ov_above) begin
      ls_on_r <= 1'b1;
    end else if (s_ov_below) begin
      ls_on_r <= 1'b0;
    end
  end

  // PWM drive per phase
  always_comb begin
    pwm_hi_nxt = '0;
    pwm_lo_nxt = '0;
    case (state_nxt)
      ST_SOFTSTART, ST_PG_DELAY, ST_REGULATE: begin
        pwm_hi_nxt = pwm_demand_i & ~(oc_hit_r | oc_now);
        pwm_lo_nxt = ~pwm_hi_nxt;
      end
      ST_OV_RECOV, ST_OV_LATCH: begin
        pwm_lo_nxt = '1;
      end
      ST_OV_RAMP: begin
        pwm_lo_nxt = {PHASES{ls_on_r}};
      end
      default: begin
        pwm_hi_nxt = '0;
        pwm_lo_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {pwm_high_on_o, pwm_low_on_o} <= '0;
    end else begin
      pwm_high_on_o <= pwm_hi_nxt;
      pwm_low_on_o  <= pwm_lo_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {power_good_flag_o, soft_start_run_o, fault_latched_o, ov_thr_fixed_o} <= 4'h0;
    end else begin
      power_good_flag_o <= (state_nxt == ST_REGULATE);
      soft_start_run_o  <= (state_nxt == ST_SOFTSTART) || (state_nxt == ST_PG_DELAY) ||
                           (state_nxt == ST_REGULATE) || (state_nxt == ST_OV_RECOV);
      fault_latched_o   <= (state_nxt == ST_OV_RAMP) || (state_nxt == ST_OV_LATCH) ||
                           (state_nxt == ST_TRI_LATCH);
      ov_thr_fixed_o    <= ov_fixed_r;
    end
  end

  bfp_iout_scale #(
    .IMON_W (IMON_W),
    .IMAX_W (IMAX_W)
  ) u_iout (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .imon_code_i (imon_code_i),
    .imax_amps_i (imax_amps_i),
    .iout_code_o (iout_code)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {rsp_valid_o, rsp_ack_o, rsp_data_o} <= {2'h0, RSP_ZERO};
    end else begin
      rsp_valid_o <= cmd_read_i;
      if (cmd_read_i && cmd_code_i == IOUT_CMD) begin
        rsp_ack_o  <= 1'b1;
        rsp_data_o <= {RSP_HI_ZERO, iout_code};
      end else begin
        rsp_ack_o  <= 1'b0;
        rsp_data_o <= RSP_ZERO;
      end
    end
  end

endmodule

/* logic/bfp_pkg.sv */
// Constants, state encoding and field positions for the buck fault supervisor.
// Assumes a single 100 MHz clock; analog comparisons arrive as digital levels.
//
// Summary of operation
// - Read-current command returns measured output current
// - Report saturates at 255, 1 A per LSB
// - Above 255 A, code 255 equals max load
// - Fault-mode pin picks recoverable or latch-off over-voltage
// - Over-voltage over 1 us: good low, low-sides on
// - Recoverable over-voltage clears 25 mV below threshold
// - Soft-start fixed threshold until good or trip
// - Latched over-voltage ramps reference down at 0.5 mV/us
// - Low-sides toggle with hysteresis during ramp down
// - Latch mode fixed threshold until ramp starts
// - Over-voltage watch from soft start, not idle
// - Under-voltage over 5 us: good low, tri-state
// - Under-voltage hiccup or latch, restart after hiccup
// - Under-voltage watch only after good delay
// - Per-phase on-time cut on over-current
// - All phases over-current 8 cycles: tri-state, fault
// - Over-current watch from soft start, not idle
// - Function pin picks temperature configuration
// - Config one: limit pin over threshold trips
// - Hiccup restart only once temperature below reset; config two restarts once not over 0.6 V
// - Config two: external temperature over 0.6 V trips
// - Mid-level means both output transistors off
package bfp_pkg;

  localparam int CLK_MHZ           = 100;
  localparam int NS_PER_US         = 1000;

  // Qualification times
  localparam int OV_QUAL_NS        = 1000;
  localparam int UV_QUAL_NS        = 5000;
  localparam int OV_QUAL_CYC       = (OV_QUAL_NS * CLK_MHZ) / NS_PER_US;
  localparam int UV_QUAL_CYC       = (UV_QUAL_NS * CLK_MHZ) / NS_PER_US;
  localparam int OV_CNT_W          = 8;
  localparam int UV_CNT_W          = 10;

  // Reference ramp: one LSB of 0.5 mV at 0.5 mV/us
  localparam int REF_LSB_UV        = 500;
  localparam int RAMP_RATE_UV_US   = 500;
  localparam int RAMP_STEP_NS      = (NS_PER_US * REF_LSB_UV) / RAMP_RATE_UV_US;
  localparam int RAMP_STEP_CYC     = (RAMP_STEP_NS * CLK_MHZ) / NS_PER_US;
  localparam int RAMP_CNT_W        = 8;

  // Over-current persistence in switching cycles
  localparam int OC_PERSIST_CYCLES = 8;
  localparam int OC_CNT_W          = 4;

  // Current report
  localparam logic [7:0]  IOUT_CMD      = 8'h8C;
  localparam logic [7:0]  IOUT_SAT      = 8'hFF;
  localparam logic [15:0] RSP_ZERO      = 16'h0000;
  localparam logic [7:0]  RSP_HI_ZERO   = 8'h00;

  // Pin encodings
  localparam logic MODE_RECOVER    = 1'b0;
  localparam logic FN_TEMP_CFG1    = 1'b0;

  // Positions inside the synchroniser vector
  localparam int SY_SUPPLY         = 0;
  localparam int SY_ENABLE         = 1;
  localparam int SY_FMODE          = 2;
  localparam int SY_FSEL           = 3;
  localparam int SY_OV_ABOVE       = 4;
  localparam int SY_OV_BELOW       = 5;
  localparam int SY_UV_BELOW       = 6;
  localparam int SY_OT1_HOT        = 7;
  localparam int SY_OT1_COOL       = 8;
  localparam int SY_OT2_HOT        = 9;
  localparam int SY_OC_BASE        = 10;

  typedef enum logic [8:0] {
    ST_DISABLED  = 9'b000000001,
    ST_SOFTSTART = 9'b000000010,
    ST_PG_DELAY  = 9'b000000100,
    ST_REGULATE  = 9'b000001000,
    ST_OV_RECOV  = 9'b000010000,
    ST_OV_RAMP   = 9'b000100000,
    ST_OV_LATCH  = 9'b001000000,
    ST_HICCUP    = 9'b010000000,
    ST_TRI_LATCH = 9'b100000000
  } bfp_state_type;

endpackage

/* logic/bfp_iout_scale.sv */
// Scales the digitised current monitor into the 8-bit output current report.
// Assumes the monitor code reaches 2**IMON_W at the programmed maximum load.
`timescale 1ns/1ns
module bfp_iout_scale #(
  parameter int IMON_W = 10,
  parameter int IMAX_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [IMON_W-1:0] imon_code_i,
  input  wire logic [IMAX_W-1:0] imax_amps_i,
  output logic      [7:0]        iout_code_o
);
  import bfp_pkg::*;

  logic [7:0]        scale;
  logic [IMON_W+7:0] product;
  logic [7:0]        amps_hi;

  assign scale   = (imax_amps_i > IMAX_W'(IOUT_SAT)) ? IOUT_SAT : imax_amps_i[7:0];
  assign product = imon_code_i * scale;
  assign amps_hi = product[IMON_W+7:IMON_W];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      iout_code_o <= 8'h00;
    end else if (amps_hi > scale) begin
      iout_code_o <= IOUT_SAT;
    end else begin
      iout_code_o <= amps_hi;
    end
  end

endmodule

/* test/bfp_core_monitor.sv */
// Concurrent checks on the fault supervisor ports, bound into bfp_core.
// Assumes bfp_pkg is compiled first and a single clock domain.
`timescale 1ns/1ns
module bfp_core_monitor
  import bfp_pkg::*;
#(
  parameter int PHASES = 6,
  parameter int REF_W  = 12
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              main_supply_5v_ok_i,
  input wire logic              enable_i,
  input wire logic              ov_above_threshold_i,
  input wire logic              uv_below_threshold_i,
  input wire logic              cmd_read_i,
  input wire logic [7:0]        cmd_code_i,
  input wire logic              power_good_flag_o,
  input wire logic [PHASES-1:0] pwm_high_on_o,
  input wire logic [PHASES-1:0] pwm_low_on_o,
  input wire logic [REF_W-1:0]  ref_code_o,
  input wire logic              fault_latched_o,
  input wire logic              rsp_valid_o,
  input wire logic              rsp_ack_o,
  input wire logic [15:0]       rsp_data_o
);
  logic [3:0] run_cnt_r;
  logic [9:0] ov_run_r;
  logic [9:0] uv_run_r;

  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Runs of enabled supply and of the raw over- and under-voltage comparator levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_cnt_r <= 4'h0;
      ov_run_r  <= 10'h000;
      uv_run_r  <= 10'h000;
    end else begin
      run_cnt_r <= !(main_supply_5v_ok_i && enable_i) ? 4'h0 :
                   (run_cnt_r == 4'h8) ? run_cnt_r : run_cnt_r + 4'h1;
      ov_run_r  <= !ov_above_threshold_i ? 10'h000 : (&ov_run_r) ? ov_run_r : ov_run_r + 10'h001;
      uv_run_r  <= !uv_below_threshold_i ? 10'h000 : (&uv_run_r) ? uv_run_r : uv_run_r + 10'h001;
    end
  end

  chk_rsp_next_cycle: assert property (cmd_read_i |=> rsp_valid_o)
    else $error("no response after command");
  chk_rsp_known_ack: assert property (cmd_read_i && cmd_code_i == IOUT_CMD |=> rsp_ack_o)
    else $error("current read not acknowledged");
  chk_rsp_unknown_zero: assert property (
    cmd_read_i && cmd_code_i != IOUT_CMD |=> !rsp_ack_o && rsp_data_o == RSP_ZERO)
    else $error("unknown command answered");
  chk_rsp_idle_quiet: assert property (
    !$past(cmd_read_i) |-> !rsp_valid_o && rsp_data_o == RSP_ZERO)
    else $error("response without command");
  chk_rsp_high_byte: assert property (rsp_valid_o |-> rsp_data_o[15:8] == RSP_HI_ZERO)
    else $error("report upper byte not zero");
  chk_ov_qualify: assert property (
    $fell(power_good_flag_o) && (&pwm_low_on_o) |-> ov_run_r >= 10'h065)
    else $error("over-voltage trip too early");
  chk_uv_qualify: assert property (
    $fell(power_good_flag_o) && pwm_high_on_o == '0 && pwm_low_on_o == '0
    && uv_below_threshold_i |-> uv_run_r >= 10'h1F5)
    else $error("under-voltage trip too early");
  chk_pull_exclusive: assert property ((pwm_high_on_o & pwm_low_on_o) == '0)
    else $error("pull-up and pull-down both on");
  chk_latch_hold: assert property (
    fault_latched_o && run_cnt_r == 4'h8 |=> fault_latched_o)
    else $error("latch cleared while enabled");
  chk_latch_high_off: assert property (
    fault_latched_o |-> pwm_high_on_o == '0 && !power_good_flag_o)
    else $error("high side on while latched");
  chk_ramp_step: assert property (
    fault_latched_o && $past(fault_latched_o) && ref_code_o != $past(ref_code_o)
    |-> ref_code_o == $past(ref_code_o) - 1'b1 ##1 $stable(ref_code_o) [*8])
    else $error("reference ramp too fast");

  cover property ($fell(power_good_flag_o) && (&pwm_low_on_o));
  cover property ($rose(fault_latched_o));
  cover property (rsp_valid_o && rsp_ack_o);
endmodule

bind bfp_core bfp_core_monitor #(.PHASES(PHASES), .REF_W(REF_W)) u_monitor (
  .clk_i, .rst_i, .main_supply_5v_ok_i, .enable_i, .ov_above_threshold_i,
  .uv_below_threshold_i, .cmd_read_i, .cmd_code_i, .power_good_flag_o, .pwm_high_on_o,
  .pwm_low_on_o, .ref_code_o, .fault_latched_o, .rsp_valid_o, .rsp_ack_o, .rsp_data_o
);

/* test/bfp_stage_model.sv */
// Behavioural power stages, sense comparators and reference generator.
// Assumes the bench steers faults and temperature through the force inputs.
`timescale 1ns/1ns
module bfp_stage_model #(
  parameter int PHASES = 6,
  parameter int SW_PER = 10,
  parameter int SS_DLY = 20
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              force_ov_i,
  input  wire logic              force_uv_i,
  input  wire logic [PHASES-1:0] force_oc_i,
  input  wire logic [1:0]        temp_i,
  input  wire logic              soft_start_run_i,
  output logic                   ov_above_o,
  output logic                   ov_below_o,
  output logic                   uv_below_o,
  output logic      [PHASES-1:0] oc_limit_o,
  output logic                   over_thermal_o,
  output logic                   below_reset_o,
  output logic                   temp_over_ref_o,
  output logic                   sw_start_o,
  output logic                   ss_done_o
);
  int sw_cnt;
  int ss_cnt;

  // Temperature 2 is hot, 1 between thresholds, 0 cool
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {ov_above_o, uv_below_o, oc_limit_o, over_thermal_o, temp_over_ref_o} <= '0;
      {ov_below_o, below_reset_o} <= 2'h3;
      sw_cnt     <= 0;
      ss_cnt     <= 0;
      sw_start_o <= 1'b0;
      ss_done_o  <= 1'b0;
    end else begin
      ov_above_o      <= force_ov_i;
      ov_below_o      <= !force_ov_i;
      uv_below_o      <= force_uv_i;
      oc_limit_o      <= force_oc_i;
      over_thermal_o  <= temp_i == 2'h2;
      below_reset_o   <= temp_i == 2'h0;
      temp_over_ref_o <= temp_i == 2'h2;
      sw_cnt          <= (sw_cnt == SW_PER - 1) ? 0 : sw_cnt + 1;
      sw_start_o      <= sw_cnt == 0;
      ss_cnt          <= !soft_start_run_i ? 0 : (ss_cnt == SS_DLY) ? ss_cnt : ss_cnt + 1;
      ss_done_o       <= soft_start_run_i && ss_cnt == SS_DLY;
    end
  end
endmodule

/* test/testbench.sv */
// Self-checking bench for the buck fault supervisor with a stage model.
// Assumes bfp_pkg, bfp_core, the monitor and the stage model are compiled first.
`timescale 1ns/1ns
module testbench;
  import bfp_pkg::*;
  logic        clk_i, rst_i, main_supply_5v_ok_i, enable_i;
  logic        fault_mode_select_pin_i, function_select_pin_i;
  logic        ov_above_threshold_i, ov_below_hysteresis_i, uv_below_threshold_i;
  logic [5:0]  oc_phase_limit_i, pwm_demand_i, pwm_high_on_o, pwm_low_on_o, force_oc;
  logic        current_limit_over_thermal_i, current_limit_below_reset_i;
  logic        external_temp_over_ref_i, sw_cycle_start_i, soft_start_done_i;
  logic [11:0] dac_code_i, ref_code_o;
  logic [9:0]  imon_code_i;
  logic [15:0] imax_amps_i, rsp_data_o;
  logic        cmd_read_i, power_good_flag_o, ov_thr_fixed_o, soft_start_run_o;
  logic        fault_latched_o, rsp_valid_o, rsp_ack_o, force_ov, force_uv;
  logic [7:0]  cmd_code_i;
  logic [1:0]  temp;
  logic [16:0] exp_q[$];
  logic [31:0] rnd;
  int          errors, checked, cycles;

  bfp_core #(.PG_DELAY_CYC(10), .HICCUP_CYC(50)) dut (
    .clk_i, .rst_i, .main_supply_5v_ok_i, .enable_i, .fault_mode_select_pin_i,
    .function_select_pin_i, .ov_above_threshold_i, .ov_below_hysteresis_i,
    .uv_below_threshold_i, .oc_phase_limit_i, .current_limit_over_thermal_i,
    .current_limit_below_reset_i, .external_temp_over_ref_i, .sw_cycle_start_i,
    .pwm_demand_i, .soft_start_done_i, .dac_code_i, .imon_code_i, .imax_amps_i,
    .cmd_read_i, .cmd_code_i, .power_good_flag_o, .pwm_high_on_o, .pwm_low_on_o,
    .ov_thr_fixed_o, .ref_code_o, .soft_start_run_o, .fault_latched_o, .rsp_valid_o,
    .rsp_ack_o, .rsp_data_o
  );

  bfp_stage_model u_stage (
    .clk_i, .rst_i, .force_ov_i(force_ov), .force_uv_i(force_uv), .force_oc_i(force_oc),
    .temp_i(temp), .soft_start_run_i(soft_start_run_o), .ov_above_o(ov_above_threshold_i),
    .ov_below_o(ov_below_hysteresis_i), .uv_below_o(uv_below_threshold_i),
    .oc_limit_o(oc_phase_limit_i), .over_thermal_o(current_limit_over_thermal_i),
    .below_reset_o(current_limit_below_reset_i), .temp_over_ref_o(external_temp_over_ref_i),
    .sw_start_o(sw_cycle_start_i), .ss_done_o(soft_start_done_i)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Waits on 0 power good, 1 latch flag, 2 reference at zero
  task automatic wait_until(input int which, input logic lvl);
    logic s;
    for (int n = 0; n < 3000; n++) begin
      s = (which == 0) ? power_good_flag_o : (which == 1) ? fault_latched_o : ref_code_o == '0;
      if (s === lvl) break;
      @(posedge clk_i);
    end
    check({16'h0, s}, {16'h0, lvl});
  endtask

  task automatic expect_pwm(input logic [11:0] pwm);
    repeat (2) @(posedge clk_i);
    check({5'h00, pwm_high_on_o, pwm_low_on_o}, {5'h00, pwm});
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      wrap_up();
    end
  end

  always @(posedge clk_i) begin
    if (!rst_i && rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(17'h1FFFF, 17'h0);
      else check({rsp_ack_o, rsp_data_o}, exp_q.pop_front());
    end
  end

  initial begin
    int sc;
    int v;
    logic [9:0] im;
    {errors, checked, cycles} = '0;
    rnd = 32'h9A9E1F5C;
    {rst_i, pwm_demand_i, dac_code_i} = {1'b1, 6'h15, 12'h003};
    {main_supply_5v_ok_i, enable_i, fault_mode_select_pin_i, function_select_pin_i} = 4'h0;
    {imon_code_i, imax_amps_i, cmd_read_i, cmd_code_i} = '0;
    {force_ov, force_uv, force_oc, temp} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    main_supply_5v_ok_i <= 1'b1;
    enable_i <= 1'b1;
    wait_until(0, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rnd = xs(rnd);
      im = (i == 4) ? 10'h3FF : rnd[9:0];
      sc = (i < 3) ? 254 + i : (i == 4) ? 1000 : int'(rnd[24:16]);
      imon_code_i <= im;
      imax_amps_i <= 16'(sc);
      sc = (sc > 255) ? 255 : sc;
      v = (int'(im) * sc) >> 10;
      repeat (2) @(posedge clk_i);
      cmd_read_i <= 1'b1;
      cmd_code_i <= IOUT_CMD;
      exp_q.push_back({9'h100, 8'((v > 255) ? 255 : v)});
      @(posedge clk_i);
      cmd_code_i <= (rnd[31:24] == IOUT_CMD) ? 8'h00 : rnd[31:24];
      exp_q.push_back(17'h0);
      @(posedge clk_i);
      cmd_read_i <= 1'b0;
    end
    pwm_demand_i <= 6'h3F;
    force_oc <= 6'h01;
    repeat (8) @(posedge clk_i);
    check({11'h0, pwm_high_on_o}, 17'h0003E);
    force_oc <= 6'h00;
    pwm_demand_i <= 6'h15;
    force_ov <= 1'b1;
    wait_until(0, 1'b0);
    expect_pwm(12'h03F);
    force_ov <= 1'b0;
    wait_until(0, 1'b1);
    expect_pwm(12'h56A);
    force_uv <= 1'b1;
    wait_until(0, 1'b0);
    expect_pwm(12'h000);
    force_uv <= 1'b0;
    wait_until(0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      function_select_pin_i <= i[0];
      temp <= 2'h2;
      wait_until(0, 1'b0);
      expect_pwm(12'h000);
      temp <= {1'b0, !i[0]};
      repeat (150) @(posedge clk_i);
      check({16'h0, power_good_flag_o}, {16'h0, i[0]});
      temp <= 2'h0;
      wait_until(0, 1'b1);
    end
    fault_mode_select_pin_i <= 1'b1;
    force_oc <= 6'h3F;
    wait_until(1, 1'b1);
    expect_pwm(12'h000);
    force_oc <= 6'h00;
    repeat (100) @(posedge clk_i);
    check({16'h0, fault_latched_o}, 17'h1);
    enable_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    enable_i <= 1'b1;
    wait_until(0, 1'b1);
    force_ov <= 1'b1;
    wait_until(1, 1'b1);
    expect_pwm(12'h03F);
    check({16'h0, ov_thr_fixed_o}, 17'h0);
    force_ov <= 1'b0;
    repeat (7) @(posedge clk_i);
    expect_pwm(12'h000);
    wait_until(2, 1'b1);
    expect_pwm(12'h03F);
    main_supply_5v_ok_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    main_supply_5v_ok_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({16'h0, ov_thr_fixed_o}, 17'h1);
    wait_until(0, 1'b1);
    check(17'(exp_q.size()), 17'h0);
    wrap_up();
  end
endmodule
